// [dma_ctl_decode.sv]
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Function
// - source width code at [20:18] gives 8, 16 or 32 bits; codes 3 to 7 are refused.
// - destination width code at [23:21] uses the same encoding as the source width.
// - differing source and destination widths are packed and unpacked by hardware.
// - destination burst code at [17:15] sets the transfers done per destination request.
// - source burst code at [14:12] sets the transfers done per source request.
// - burst code 0 means 1 transfer and codes 1 to 7 mean 4 up to 256 transfers.
// - the request burst size has no bearing on the bus burst type that is issued.
// - writing the twelve-bit count at [11:0] sets the transfers when this block flows.
// - the count falls toward zero per destination transfer and reads as what remains.
// - the three protection bits go out as bus attributes on every channel transfer.
// - protection bit 0 drives attribute bit 1, user or privileged.
// - protection bit 1 drives attribute bit 2, non-bufferable or bufferable.
// - protection bit 2 drives attribute bit 3, non-cacheable or cacheable.
module dma_ctl_decode (
   input  wire logic                           CLK_I,
   input  wire logic                           SRST_I,
   input  wire logic                           HSEL_I,
   input  wire logic [31:0]                    HADDR_I,
   input  wire logic [1:0]                     HTRANS_I,
   input  wire logic                           HWRITE_I,
   input  wire logic [2:0]                     HSIZE_I,
   input  wire logic [31:0]                    HWDATA_I,
   input  wire logic                           HREADY_I,
   output logic [31:0]                         HRDATA_O,
   output logic                                HREADYOUT_O,
   output logic                                HRESP_O,
   input  wire logic                           SRC_BREQ_I,
   input  wire logic                           DST_BREQ_I,
   input  wire logic [31:0]                    SRC_DATA_I,
   input  wire logic                           SRC_VALID_I,
   output logic                                SRC_READY_O,
   output logic [31:0]                         DST_DATA_O,
   output logic                                DST_VALID_O,
   input  wire logic                           DST_READY_I,
   output logic [2:0]                          SRC_SIZE_O,
   output logic [2:0]                          DST_SIZE_O,
   output logic [3:0]                          HPROT_O,
   output logic [2:0]                          HBURST_O,
   output logic [dma_ctl_pkg::BLEN_W-1:0]      SRC_BURST_LEN_O,
   output logic [dma_ctl_pkg::BLEN_W-1:0]      DST_BURST_LEN_O,
   output logic                                CH_ACTIVE_O
);
   import dma_ctl_pkg::*;

   logic [31:0]        ctrl_r;
   logic [31:0]        ctrl_nxt;
   logic [CNT_W-1:0]   cnt_r;
   logic [CNT_W-1:0]   cnt_nxt;
   logic               en_r;
   logic               en_nxt;
   logic               flow_r;
   logic               flow_nxt;
   logic               wr_pend_r;
   logic [31:0]        wr_addr_r;
   logic [31:0]        rdata_r;
   logic [31:0]        rd_val;
   logic               addr_ph;
   logic               wr_ctrl;
   logic               wr_chen;
   logic [1:0]         breq_s1_r;
   logic [1:0]         breq_s2_r;
   logic [1:0]         breq_d_r;
   logic               src_rise;
   logic               dst_rise;
   logic [BLEN_W-1:0]  src_left_r;
   logic [BLEN_W-1:0]  dst_left_r;
   logic [2:0]         sw_code;
   logic [2:0]         dw_code;
   logic [2:0]         sw_bytes;
   logic [2:0]         dw_bytes;
   logic               width_ok;
   logic               src_hs;
   logic               dst_hs;
   logic               pk_in_ready;
   logic               pk_out_valid;
   logic [3:0]         pk_level;

   function automatic logic [2:0] width_bytes(input logic [2:0] code);
      unique case (code)
         WIDTH_BYTE: width_bytes = 3'h1;
         WIDTH_HALF: width_bytes = 3'h2;
         WIDTH_WORD: width_bytes = 3'h4;
         default:    width_bytes = 3'h0;
      endcase
   endfunction

   function automatic logic [BLEN_W-1:0] burst_len(input logic [2:0] code);
      burst_len = (code == 3'h0) ? BLEN_W'(1) : BLEN_W'(2) << code;
   endfunction

   // field decode
   assign sw_code  = ctrl_r[SW_LSB +: CODE_W];
   assign dw_code  = ctrl_r[DW_LSB +: CODE_W];
   assign sw_bytes = width_bytes(sw_code);
   assign dw_bytes = width_bytes(dw_code);
   // wider than the 32-bit bus or reserved: channel will not start
   assign width_ok = (sw_code <= WIDTH_WORD) && (dw_code <= WIDTH_WORD);

   assign SRC_SIZE_O      = sw_code;
   assign DST_SIZE_O      = dw_code;
   assign SRC_BURST_LEN_O = burst_len(ctrl_r[SB_LSB +: CODE_W]);
   assign DST_BURST_LEN_O = burst_len(ctrl_r[DB_LSB +: CODE_W]);
   // single transfers only, whatever the request burst length
   assign HBURST_O        = HBURST_SINGLE;
   assign HPROT_O         = {ctrl_r[PROT_LSB + 2],
                             ctrl_r[PROT_LSB + 1],
                             ctrl_r[PROT_LSB],
                             HPROT_DATA};

   // bus slave: zero wait states, always okay
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;
   assign HRDATA_O    = rdata_r;
   assign addr_ph     = HSEL_I & HTRANS_I[1] & HREADY_I;
   assign wr_ctrl     = wr_pend_r && (wr_addr_r == CTRL_OFS);
   assign wr_chen     = wr_pend_r && (wr_addr_r == CHEN_OFS);

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         wr_pend_r <= addr_ph & HWRITE_I;
         wr_addr_r <= {HADDR_I[31:2], 2'b00};
      end
   end

   // next-state values; a software write beats a hardware update in the same cycle
   always_comb begin
      ctrl_nxt = ctrl_r;
      cnt_nxt  = cnt_r;
      en_nxt   = en_r;
      flow_nxt = flow_r;
      if (dst_hs && cnt_r != '0) begin
         cnt_nxt = cnt_r - CNT_W'(1);
         if (flow_r && cnt_r == CNT_W'(1)) begin
            en_nxt = 1'b0;
         end
      end
      if (wr_ctrl) begin
         ctrl_nxt = HWDATA_I;
         cnt_nxt  = HWDATA_I[CNT_LSB +: CNT_W];
      end
      if (wr_chen) begin
         en_nxt = HWDATA_I[EN_BIT] & width_ok;
         if (HWDATA_I[EN_BIT] && !en_r) begin
            // a zero count means a peripheral ends the transfer
            flow_nxt = cnt_r != '0;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         ctrl_r <= CTRL_RST;
         cnt_r  <= CTRL_RST[CNT_LSB +: CNT_W];
      end else begin
         ctrl_r <= ctrl_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         en_r   <= EN_RST;
         flow_r <= 1'b0;
      end else begin
         en_r   <= en_nxt;
         flow_r <= flow_nxt;
      end
   end

   // read mux works on next values so a read right behind a write sees it
   always_comb begin
      rd_val = 32'h0000_0000;
      if ({HADDR_I[31:2], 2'b00} == CTRL_OFS) begin
         rd_val = {ctrl_nxt[31:CNT_W], cnt_nxt};
      end else if ({HADDR_I[31:2], 2'b00} == CHEN_OFS) begin
         rd_val[EN_BIT]   = en_nxt;
         rd_val[ACT_BIT]  = pk_level != 4'h0;
         rd_val[WERR_BIT] = ~width_ok;
         rd_val[FLOW_BIT] = flow_nxt;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         rdata_r <= '0;
      end else if (addr_ph && !HWRITE_I) begin
         rdata_r <= rd_val;
      end
   end

   // request lines come from pins: two flops before use
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         breq_s1_r <= '0;
         breq_s2_r <= '0;
         breq_d_r  <= '0;
      end else begin
         breq_s1_r <= {DST_BREQ_I, SRC_BREQ_I};
         breq_s2_r <= breq_s1_r;
         breq_d_r  <= breq_s2_r;
      end
   end

   assign src_rise = breq_s2_r[0] & ~breq_d_r[0];
   assign dst_rise = breq_s2_r[1] & ~breq_d_r[1];

   // a request arriving mid-burst is ignored; the burst is not restartable
   always_ff @(posedge CLK_I) begin
      if (SRST_I || !en_r) begin
         src_left_r <= '0;
      end else if (src_rise && src_left_r == '0) begin
         src_left_r <= SRC_BURST_LEN_O;
      end else if (src_hs) begin
         src_left_r <= src_left_r - BLEN_W'(1);
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I || !en_r) begin
         dst_left_r <= '0;
      end else if (dst_rise && dst_left_r == '0) begin
         dst_left_r <= DST_BURST_LEN_O;
      end else if (dst_hs) begin
         dst_left_r <= dst_left_r - BLEN_W'(1);
      end
   end

   assign SRC_READY_O = en_r && src_left_r != '0 && pk_in_ready;
   assign DST_VALID_O = en_r && dst_left_r != '0 && pk_out_valid;
   assign src_hs      = SRC_READY_O & SRC_VALID_I;
   assign dst_hs      = DST_VALID_O & DST_READY_I;
   assign CH_ACTIVE_O = en_r;

   // byte-lane packer between source and destination widths
   pack_unit #(
      .DW (32)
   ) u_pack (
      .clk_i       (CLK_I),
      .srst_i      (SRST_I),
      .clear_i     (~en_r),
      .in_bytes_i  (sw_bytes),
      .out_bytes_i (dw_bytes),
      .in_valid_i  (SRC_VALID_I & en_r & (src_left_r != '0)),
      .in_data_i   (SRC_DATA_I),
      .in_ready_o  (pk_in_ready),
      .out_valid_o (pk_out_valid),
      .out_ready_i (DST_READY_I & en_r & (dst_left_r != '0)),
      .out_data_o  (DST_DATA_O),
      .level_o     (pk_level)
   );

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SRST_I);

   property p_width_start;
      $rose(en_r) |-> $past(width_ok) && width_ok;
   endproperty
   a_width_start: assert property (p_width_start) else $error("enabled with bad width");

   property p_src_load;
      (src_rise && en_r && src_left_r == '0) |=> (src_left_r == $past(SRC_BURST_LEN_O));
   endproperty
   a_src_load: assert property (p_src_load) else $error("source burst not loaded");

   property p_dst_load;
      (dst_rise && en_r && dst_left_r == '0) |=> (dst_left_r == $past(DST_BURST_LEN_O));
   endproperty
   a_dst_load: assert property (p_dst_load) else $error("dest burst not loaded");

   property p_blen_top;
      (ctrl_r[SB_LSB +: CODE_W] == 3'h7) |-> (SRC_BURST_LEN_O == 9'h100);
   endproperty
   a_blen_top: assert property (p_blen_top) else $error("burst code 7 not 256");

   property p_blen_one;
      (ctrl_r[DB_LSB +: CODE_W] == 3'h0) |-> (DST_BURST_LEN_O == 9'h001);
   endproperty
   a_blen_one: assert property (p_blen_one) else $error("burst code 0 not 1");

   property p_cnt_dec;
      (dst_hs && !wr_ctrl && cnt_r != '0) |=> (cnt_r == $past(cnt_r) - 12'h001);
   endproperty
   a_cnt_dec: assert property (p_cnt_dec) else $error("count did not fall");

   property p_done_stop;
      (flow_r && dst_hs && cnt_r == 12'h001 && !wr_chen) |=> !en_r ##1 !DST_VALID_O;
   endproperty
   a_done_stop: assert property (p_done_stop) else $error("channel ran past count");

   property p_prot_map;
      HPROT_O == {ctrl_r[PROT_LSB + 2], ctrl_r[PROT_LSB + 1], ctrl_r[PROT_LSB], 1'b1};
   endproperty
   a_prot_map: assert property (p_prot_map) else $error("attribute bits wrong");

   property p_burst_single;
      $rose(dst_left_r != '0) |-> HBURST_O == HBURST_SINGLE;
   endproperty
   a_burst_single: assert property (p_burst_single) else $error("burst type coupled");

   property p_pack_level;
      DST_VALID_O |-> (pk_level >= {1'b0, dw_bytes}) && dw_bytes != 3'h0;
   endproperty
   a_pack_level: assert property (p_pack_level) else $error("short destination unit");

   property p_read_cnt;
      (addr_ph && !HWRITE_I && {HADDR_I[31:2], 2'b00} == CTRL_OFS)
         |=> (HRDATA_O[CNT_W-1:0] == cnt_r);
   endproperty
   a_read_cnt: assert property (p_read_cnt) else $error("count read back wrong");

   // each accepted unit spends exactly one unit of burst credit
   property p_src_step;
      src_hs |=> (src_left_r == $past(src_left_r) - 9'h001);
   endproperty
   a_src_step: assert property (p_src_step) else $error("source credit not spent");

   property p_dst_step;
      dst_hs |=> (dst_left_r == $past(dst_left_r) - 9'h001);
   endproperty
   a_dst_step: assert property (p_dst_step) else $error("dest credit not spent");

   property p_flow_set;
      (wr_chen && HWDATA_I[EN_BIT] && !en_r && width_ok)
         |=> en_r && (flow_r == ($past(cnt_r) != '0));
   endproperty
   a_flow_set: assert property (p_flow_set) else $error("flow mode wrong at enable");

   property p_bad_refused;
      (wr_chen && !width_ok) |=> !en_r;
   endproperty
   a_bad_refused: assert property (p_bad_refused) else $error("reserved width enabled");

   c_refused: cover property (wr_chen && !width_ok);
   c_mixed_width: cover property (dst_hs && sw_code != dw_code);
   c_done: cover property (flow_r && en_r ##1 !en_r);
   c_full_burst: cover property (src_hs && src_left_r == 9'h001);
endmodule

// [dma_ctl_pkg.sv]
package dma_ctl_pkg;
   // register byte offsets
   localparam logic [31:0] CTRL_OFS     = 32'h0000_0000;
   localparam logic [31:0] CHEN_OFS     = 32'h0000_0004;
   // control word fields
   localparam int          PROT_LSB     = 28;
   localparam int          DW_LSB       = 21;
   localparam int          SW_LSB       = 18;
   localparam int          DB_LSB       = 15;
   localparam int          SB_LSB       = 12;
   localparam int          CNT_LSB      = 0;
   localparam int          CNT_W        = 12;
   localparam int          CODE_W       = 3;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   // channel enable / status word fields
   localparam int          EN_BIT       = 0;
   localparam int          ACT_BIT      = 1;
   localparam int          WERR_BIT     = 2;
   localparam int          FLOW_BIT     = 3;
   localparam logic        EN_RST       = 1'b0;
   // width codes, equal to the bus size encoding
   localparam logic [2:0]  WIDTH_BYTE   = 3'h0;
   localparam logic [2:0]  WIDTH_HALF   = 3'h1;
   localparam logic [2:0]  WIDTH_WORD   = 3'h2;
   // bus attributes
   localparam logic [2:0]  HBURST_SINGLE = 3'h0;
   localparam logic        HPROT_DATA   = 1'b1;
   localparam int          BLEN_W       = 9;
endpackage

// [dma_periph_model.sv]
`timescale 1ns/1ps
module dma_periph_model (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        go_i,
   input  wire logic        slow_i,
   input  wire logic        src_ready_i,
   input  wire logic [31:0] dst_data_i,
   input  wire logic        dst_valid_i,
   output logic             src_breq_o,
   output logic             dst_breq_o,
   output logic [31:0]      src_data_o,
   output logic             src_valid_o,
   output logic             dst_ready_o,
   output logic [31:0]      rx0_o,
   output logic [31:0]      rx1_o,
   output logic [3:0]       rx_cnt_o
);
   logic [2:0] phase_r;
   logic [7:0] byte_r;
   logic [7:0] junk_r;
   always_ff @(posedge clk_i) begin
      phase_r <= srst_i ? 3'h0 : phase_r + 3'h1;
      junk_r  <= srst_i ? 8'hA5 : ~junk_r + 8'h3;
   end
   // each side asks for one burst per eight cycles, whatever its burst code
   assign src_breq_o  = go_i & phase_r[2];
   assign dst_breq_o  = go_i & ~phase_r[2];
   assign src_valid_o = go_i;
   // only lane 0 is meaningful for byte units; other lanes churn
   assign src_data_o  = src_valid_o ? {junk_r, junk_r, junk_r, byte_r} : {4{junk_r}};
   assign dst_ready_o = slow_i ? phase_r[0] : 1'b1;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         byte_r   <= 8'h10;
         rx_cnt_o <= 4'h0;
         rx0_o    <= 32'h0;
         rx1_o    <= 32'h0;
      end else begin
         if (src_valid_o && src_ready_i) byte_r <= byte_r + 8'h1;
         if (dst_valid_i && dst_ready_o) begin
            if (rx_cnt_o == 4'h0) rx0_o <= dst_data_i;
            if (rx_cnt_o == 4'h1) rx1_o <= dst_data_i;
            rx_cnt_o <= rx_cnt_o + 4'h1;
         end
      end
   end
endmodule

// [pack_unit.sv]
`timescale 1ns/1ps
module pack_unit #(
   parameter int DW = 32
) (
   input  wire logic          clk_i,
   input  wire logic          srst_i,
   input  wire logic          clear_i,
   input  wire logic [2:0]    in_bytes_i,
   input  wire logic [2:0]    out_bytes_i,
   input  wire logic          in_valid_i,
   input  wire logic [DW-1:0] in_data_i,
   output logic               in_ready_o,
   output logic               out_valid_o,
   input  wire logic          out_ready_i,
   output logic [DW-1:0]      out_data_o,
   output logic [3:0]         level_o
);
   logic [DW-1:0]   buf_r;
   logic [DW-1:0]   buf_nxt;
   logic [3:0]      cnt_r;
   logic [3:0]      cnt_nxt;
   logic [3:0]      rem;
   logic            pop;
   logic            push;
   logic [DW-1:0]   shifted;
   logic [DW-1:0]   in_mask;
   logic [2*DW-1:0] placed;

   assign out_valid_o = cnt_r >= {1'b0, out_bytes_i};
   assign pop         = out_valid_o & out_ready_i;
   assign rem         = pop ? cnt_r - {1'b0, out_bytes_i} : cnt_r;
   // room is judged after this cycle's pop so a full word can stream through
   assign in_ready_o  = (rem + {1'b0, in_bytes_i}) <= 4'(DW / 8);
   assign push        = in_valid_i & in_ready_o;
   assign out_data_o  = buf_r;
   assign level_o     = cnt_r;

   always_comb begin
      shifted = pop ? buf_r >> {out_bytes_i, 3'b000} : buf_r;
      in_mask = ~({DW{1'b1}} << {in_bytes_i, 3'b000});
      placed  = {{DW{1'b0}}, in_data_i & in_mask} << {rem, 3'b000};
      buf_nxt = push ? shifted | placed[DW-1:0] : shifted;
      cnt_nxt = push ? rem + {1'b0, in_bytes_i} : rem;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || clear_i) begin
         buf_r <= '0;
         cnt_r <= '0;
      end else begin
         buf_r <= buf_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// [test_dma_channel_control_decode.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module test_dma_channel_control_decode;
   import dma_ctl_pkg::*;
   logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, slow = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dst_data, src_data, rx0, rx1, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2, src_size, dst_size, hburst;
   logic [3:0]  hprot, rx_cnt;
   logic [8:0]  sblen, dblen;
   logic hready, hresp, sbreq, dbreq, svalid, sready, dvalid, dready, active;
   int n_fail = 0, checked = 0;
   initial forever #5 clk = ~clk;
   dma_ctl_decode u_dut (.CLK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .SRC_BREQ_I(sbreq), .DST_BREQ_I(dbreq), .SRC_DATA_I(src_data), .SRC_VALID_I(svalid),
      .SRC_READY_O(sready), .DST_DATA_O(dst_data), .DST_VALID_O(dvalid),
      .DST_READY_I(dready), .SRC_SIZE_O(src_size), .DST_SIZE_O(dst_size), .HPROT_O(hprot),
      .HBURST_O(hburst), .SRC_BURST_LEN_O(sblen), .DST_BURST_LEN_O(dblen),
      .CH_ACTIVE_O(active));
   dma_periph_model u_periph (.clk_i(clk), .srst_i(srst), .go_i(go), .slow_i(slow),
      .src_ready_i(sready), .dst_data_i(dst_data), .dst_valid_i(dvalid),
      .src_breq_o(sbreq), .dst_breq_o(dbreq), .src_data_o(src_data), .src_valid_o(svalid),
      .dst_ready_o(dready), .rx0_o(rx0), .rx1_o(rx1), .rx_cnt_o(rx_cnt));
   // address phase held until hready, then data phase; read data taken at its end
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
      @(posedge clk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      ahb(1'b1, a, d, dummy);
      #1;
   endtask
   task automatic rdr(input logic [31:0] a);
      ahb(1'b0, a, 32'h0, rd);
      #1;
   endtask
   task automatic complete_run;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic t_reset_state;
      `CHK("hprot", 4'h1, hprot)
      `CHK("sblen", 9'h001, sblen)
      `CHK("active", 1'b0, active)
      rdr(CTRL_OFS);
      `CHK("ctrl rst", CTRL_RST, rd)
      `CHK("hresp", 1'b0, hresp)
   endtask
   task automatic t_field_decode;
      logic [31:0] w;
      logic [2:0]  c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         w = (32'(c) << PROT_LSB) | (32'(3'h7 - c) << DB_LSB) | (32'(c) << SB_LSB)
           | (32'(i % 3) << DW_LSB) | (32'((i + 1) % 3) << SW_LSB);
         wr(CTRL_OFS, w);
         `CHK("sblen", (c == 3'h0) ? 9'h001 : 9'(1 << (i + 1)), sblen)
         `CHK("dblen", (c == 3'h7) ? 9'h001 : 9'(1 << (8 - i)), dblen)
         `CHK("dsize", 3'(i % 3), dst_size)
         `CHK("ssize", 3'((i + 1) % 3), src_size)
         `CHK("hprot1", c[0], hprot[1])
         `CHK("hprot2", c[1], hprot[2])
         `CHK("hprot3", c[2], hprot[3])
         `CHK("hprot0", HPROT_DATA, hprot[0])
         `CHK("hburst", HBURST_SINGLE, hburst)
         rdr(CTRL_OFS);
         `CHK("ctrl rb", w, rd)
      end
   endtask
   task automatic t_reserved_width;
      for (int k = 3; k < 8; k++) begin
         wr(CTRL_OFS, 32'(k) << ((k % 2 == 1) ? SW_LSB : DW_LSB));
         wr(CHEN_OFS, 32'h1);
         rdr(CHEN_OFS);
         `CHK("en refused", 1'b0, rd[EN_BIT])
         `CHK("width err", 1'b1, rd[WERR_BIT])
         `CHK("active", 1'b0, active)
      end
      wr(32'h0000_0008, 32'hFFFF_FFFF);
      rdr(32'h0000_0008);
      `CHK("unmapped", 32'h0, rd)
   endtask
   // bytes in, words out, two words counted down with a stalling receiver
   task automatic t_flow_pack;
      int n;
      wr(CTRL_OFS, (32'(WIDTH_WORD) << DW_LSB) | (32'h1 << SB_LSB) | 32'h2);
      rdr(CTRL_OFS);
      `CHK("count set", 12'h002, rd[11:0])
      `CHK("word width", WIDTH_WORD, dst_size)
      go <= 1'b1;
      slow <= 1'b1;
      wr(CHEN_OFS, 32'h1);
      `CHK("active", 1'b1, active)
      n = 0;
      while (active === 1'b1 && n < 600) begin
         @(posedge clk);
         #1;
         n++;
      end
      #1;
      `CHK("stopped", 1'b0, active)
      go <= 1'b0;
      `CHK("words", 4'h2, rx_cnt)
      `CHK("word0", 32'h1312_1110, rx0)
      `CHK("word1", 32'h1716_1514, rx1)
      rdr(CTRL_OFS);
      `CHK("count left", 12'h000, rd[11:0])
      rdr(CHEN_OFS);
      `CHK("flow flag", 1'b1, rd[FLOW_BIT])
      wr(CTRL_OFS, 32'h0);
   endtask
   initial begin
      #200000;
      n_fail++;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset_state;
      t_field_decode;
      t_reserved_width;
      t_flow_pack;
      complete_run;
   end
endmodule
